/* serial_control_pkg.sv */
package serial_control_pkg;

  // Control register layout; bit 7 down to bit 0.
  typedef struct packed {
    logic interrupt_enable_bit;
    logic peripheral_enable_bit;
    logic divider_disable_bit;
    logic master_select_bit;
    logic clock_polarity;
    logic clock_phase;
    logic [1:0] rate_select_bits;
  } serial_control_ctrl_s;

  // Pin controls for the serial pads.
  typedef struct packed {
    logic sck_oe_n;
    logic mosi_oe_n;
    logic miso_oe_n;
    logic alt_enable;
  } serial_control_pins_s;

  localparam logic [7:0] SERIAL_CONTROL_ADR_CTRL = 8'h00;
  localparam logic [7:0] SERIAL_CONTROL_ADR_STATUS = 8'h04;
  localparam logic [7:0] SERIAL_CONTROL_ADR_MASK = 8'h08;

  localparam logic [7:0] SERIAL_CONTROL_CTRL_RESET = 8'h00;
  localparam logic [7:0] SERIAL_CONTROL_STATUS_RESET = 8'h00;
  localparam logic [7:0] SERIAL_CONTROL_MASK_RESET = 8'hB0;

  localparam int SERIAL_CONTROL_BIT_DONE = 7;
  localparam int SERIAL_CONTROL_BIT_OVERRUN = 5;
  localparam int SERIAL_CONTROL_BIT_FAULT = 4;
  localparam logic [7:0] SERIAL_CONTROL_STATUS_USED = 8'hB0;

  // Half periods of SCK in CPU cycles per rate code with the divide-by-2 stage active.
  localparam logic [6:0] SERIAL_CONTROL_HALF_R0 = 7'h04;
  localparam logic [6:0] SERIAL_CONTROL_HALF_R1 = 7'h08;
  localparam logic [6:0] SERIAL_CONTROL_HALF_R2 = 7'h20;
  localparam logic [6:0] SERIAL_CONTROL_HALF_R3 = 7'h40;

endpackage : serial_control_pkg

/* serial_control_core.sv */
`timescale 1ns/1ps
`default_nettype none

module serial_control_core #(
  parameter int BYTE_EDGES = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ss_n_i,
  input wire logic sck_i,
  input wire logic xfer_active_i,
  input wire logic transfer_done_i,
  input wire logic overrun_i,
  output logic sck_o,
  output serial_control_pkg::serial_control_pins_s pins_o,
  output serial_control_pkg::serial_control_ctrl_s ctrl_o,
  output logic capture_o,
  output logic shift_o,
  output logic irq_o
);

  if (BYTE_EDGES < 2 || BYTE_EDGES > 16 || BYTE_EDGES % 2 != 0) begin : g_chk
    $error("BYTE_EDGES must be even and between 2 and 16");
  end

  serial_control_pkg::serial_control_ctrl_s ctrl_reg;
  logic [7:0] status_reg;
  logic [7:0] mask_reg;
  logic arm_reg;
  logic ack_reg;
  logic [31:0] dat_reg;
  logic [6:0] half_cnt_reg;
  logic tog_reg;
  logic sck_prev_reg;
  logic [4:0] edge_cnt_reg;

  logic fire;
  logic wr_ctrl;
  logic wr_status;
  logic wr_mask;
  logic rd_status;
  logic fault_evt;
  logic lock_out;
  logic [7:0] status_set;
  logic [7:0] status_clr;
  logic [7:0] rd_data;
  logic [6:0] half_base;
  logic [6:0] half;
  logic run;
  logic mst_edge;
  logic slv_edge;
  logic sck_edge;
  logic cap_sel;
  logic in_byte;

  // Requests are taken once; ack follows one cycle later and then drops.
  assign fire = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wr_ctrl = fire & wb_we_i & wb_sel_i[0] & (wb_adr_i == serial_control_pkg::SERIAL_CONTROL_ADR_CTRL);
  assign wr_status = fire & wb_we_i & wb_sel_i[0] & (wb_adr_i == serial_control_pkg::SERIAL_CONTROL_ADR_STATUS);
  assign wr_mask = fire & wb_we_i & wb_sel_i[0] & (wb_adr_i == serial_control_pkg::SERIAL_CONTROL_ADR_MASK);
  assign rd_status = fire & ~wb_we_i & (wb_adr_i == serial_control_pkg::SERIAL_CONTROL_ADR_STATUS);
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  always_comb begin
    case (wb_adr_i)
      serial_control_pkg::SERIAL_CONTROL_ADR_CTRL: rd_data = ctrl_reg;
      serial_control_pkg::SERIAL_CONTROL_ADR_STATUS: rd_data = status_reg;
      serial_control_pkg::SERIAL_CONTROL_ADR_MASK: rd_data = mask_reg;
      default: rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= fire;
      if (fire) begin
        dat_reg <= {24'h00_0000, rd_data};
      end
    end
  end

  // Fault is detected on the master bit alone, so a disabled master still trips it.
  assign fault_evt = ctrl_reg.master_select_bit & ~ss_n_i;
  // Outside the clear sequence a set fault flag blocks enable and master.
  assign lock_out = status_reg[serial_control_pkg::SERIAL_CONTROL_BIT_FAULT] & ~arm_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= serial_control_pkg::SERIAL_CONTROL_CTRL_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= wb_dat_i[7:0];
        if (lock_out) begin
          ctrl_reg.peripheral_enable_bit <= 1'b0;
          ctrl_reg.master_select_bit <= 1'b0;
        end
      end
      if (fault_evt) begin
        ctrl_reg.peripheral_enable_bit <= 1'b0;
        ctrl_reg.master_select_bit <= 1'b0;
      end
    end
  end

  // A status read while the fault flag is set arms the clear sequence.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      arm_reg <= 1'b0;
    end else if (wr_ctrl) begin
      arm_reg <= 1'b0;
    end else if (rd_status && status_reg[serial_control_pkg::SERIAL_CONTROL_BIT_FAULT]) begin
      arm_reg <= 1'b1;
    end
  end

  always_comb begin
    status_set = 8'h00;
    status_set[serial_control_pkg::SERIAL_CONTROL_BIT_DONE] = transfer_done_i;
    status_set[serial_control_pkg::SERIAL_CONTROL_BIT_OVERRUN] = overrun_i;
    status_set[serial_control_pkg::SERIAL_CONTROL_BIT_FAULT] = fault_evt;
    status_clr = wr_status ? wb_dat_i[7:0] : 8'h00;
    if (wr_ctrl && arm_reg) begin
      status_clr[serial_control_pkg::SERIAL_CONTROL_BIT_FAULT] = 1'b1;
    end
  end

  // Setting wins over clearing, so an event in the clear cycle survives.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_reg <= serial_control_pkg::SERIAL_CONTROL_STATUS_RESET;
    end else begin
      status_reg <= ((status_reg & ~status_clr) | status_set) & serial_control_pkg::SERIAL_CONTROL_STATUS_USED;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_reg <= serial_control_pkg::SERIAL_CONTROL_MASK_RESET;
    end else if (wr_mask) begin
      mask_reg <= wb_dat_i[7:0] & serial_control_pkg::SERIAL_CONTROL_STATUS_USED;
    end
  end

  assign irq_o = ctrl_reg.interrupt_enable_bit & (|(status_reg & mask_reg));

  // Divide ratio is the rate code's base, halved when the divide-by-2 stage is bypassed.
  always_comb begin
    case (ctrl_reg.rate_select_bits)
      2'b00: half_base = serial_control_pkg::SERIAL_CONTROL_HALF_R0;
      2'b01: half_base = serial_control_pkg::SERIAL_CONTROL_HALF_R1;
      2'b10: half_base = serial_control_pkg::SERIAL_CONTROL_HALF_R2;
      2'b11: half_base = serial_control_pkg::SERIAL_CONTROL_HALF_R3;
      default: half_base = serial_control_pkg::SERIAL_CONTROL_HALF_R3;
    endcase
  end

  assign half = ctrl_reg.divider_disable_bit ? (half_base >> 1) : half_base;
  // The rate generator only runs as an enabled master.
  assign run = ctrl_reg.master_select_bit & ctrl_reg.peripheral_enable_bit & xfer_active_i;
  assign mst_edge = run & (half_cnt_reg == half - 7'h01);

  always_ff @(posedge clk_i) begin
    if (rst_i || !run) begin
      half_cnt_reg <= 7'h00;
      tog_reg <= 1'b0;
    end else if (mst_edge) begin
      half_cnt_reg <= 7'h00;
      tog_reg <= ~tog_reg;
    end else begin
      half_cnt_reg <= half_cnt_reg + 7'h01;
    end
  end

  // Slave edges come from the external clock, sampled as a synchronous input.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sck_prev_reg <= 1'b0;
    end else begin
      sck_prev_reg <= sck_i;
    end
  end

  assign slv_edge = ~ctrl_reg.master_select_bit & ctrl_reg.peripheral_enable_bit
                    & xfer_active_i & (sck_i != sck_prev_reg);
  assign sck_edge = mst_edge | slv_edge;

  // The count stops at BYTE_EDGES, so a clock that runs on past the byte cannot wrap
  // back into a second set of capture strobes.
  assign in_byte = (edge_cnt_reg < 5'(BYTE_EDGES));

  always_ff @(posedge clk_i) begin
    if (rst_i || !xfer_active_i) begin
      edge_cnt_reg <= 5'h00;
    end else if (sck_edge && in_byte) begin
      edge_cnt_reg <= edge_cnt_reg + 5'h01;
    end
  end

  // Even edge index is the first, third, ... transition of the byte.
  assign cap_sel = (edge_cnt_reg[0] == ctrl_reg.clock_phase);
  assign capture_o = sck_edge & cap_sel & in_byte;
  assign shift_o = sck_edge & ~cap_sel & in_byte;

  // Idle level is the polarity bit; only an enabled master toggles away from it.
  assign sck_o = ctrl_reg.clock_polarity ^ tog_reg;

  always_comb begin
    pins_o.alt_enable = ctrl_reg.peripheral_enable_bit;
    pins_o.sck_oe_n = ~(ctrl_reg.peripheral_enable_bit & ctrl_reg.master_select_bit);
    pins_o.mosi_oe_n = ~(ctrl_reg.peripheral_enable_bit & ctrl_reg.master_select_bit);
    pins_o.miso_oe_n = ~(ctrl_reg.peripheral_enable_bit & ~ctrl_reg.master_select_bit);
  end

  assign ctrl_o = ctrl_reg;

  a_irq_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    !ctrl_reg.interrupt_enable_bit |-> !irq_o)
    else $error("interrupt raised while disabled");

  a_irq_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_reg.interrupt_enable_bit && (status_reg & mask_reg) != 8'h00) |-> irq_o)
    else $error("interrupt missing for set flag");

  a_fault_clears: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_reg.master_select_bit && !ss_n_i) |=> (!ctrl_reg.master_select_bit
      && !ctrl_reg.peripheral_enable_bit && status_reg[serial_control_pkg::SERIAL_CONTROL_BIT_FAULT]))
    else $error("mode fault not handled");

  a_reset_clear: assert property (@(posedge clk_i)
    rst_i |=> (!ctrl_reg.peripheral_enable_bit && !ctrl_reg.divider_disable_bit
      && pins_o.sck_oe_n && !pins_o.alt_enable))
    else $error("reset left control bits set");

  a_fault_lock: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_ctrl && lock_out && !fault_evt) |=> (!ctrl_reg.peripheral_enable_bit
      && !ctrl_reg.master_select_bit))
    else $error("enable set during fault");

  a_slave_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    !ctrl_reg.master_select_bit |=> (!mst_edge && sck_o == ctrl_reg.clock_polarity))
    else $error("slave generated clock");

  a_pin_roles: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(ctrl_reg.master_select_bit && ctrl_reg.peripheral_enable_bit)
      |-> (!pins_o.sck_oe_n && !pins_o.mosi_oe_n && pins_o.miso_oe_n))
    else $error("master pin roles wrong");

  a_idle_level: assert property (@(posedge clk_i) disable iff (rst_i)
    !xfer_active_i |=> sck_o == ctrl_reg.clock_polarity)
    else $error("idle clock level wrong");

  a_fast_rate: assert property (@(posedge clk_i) disable iff (rst_i)
    (mst_edge && ctrl_reg.divider_disable_bit && ctrl_reg.rate_select_bits == 2'b00)
      |=> !mst_edge ##1 (mst_edge || !run || !ctrl_reg.divider_disable_bit))
    else $error("divide by 4 timing wrong");

  a_first_capture: assert property (@(posedge clk_i) disable iff (rst_i)
    (sck_edge && edge_cnt_reg == 5'h00) |-> (capture_o == !ctrl_reg.clock_phase))
    else $error("first capture edge wrong");

  a_second_capture: assert property (@(posedge clk_i) disable iff (rst_i)
    (sck_edge && edge_cnt_reg == 5'h01)
      |-> (capture_o == ctrl_reg.clock_phase && shift_o == !ctrl_reg.clock_phase))
    else $error("second edge role wrong");

  a_byte_limit: assert property (@(posedge clk_i) disable iff (rst_i)
    (edge_cnt_reg >= 5'(BYTE_EDGES)) |-> (!capture_o && !shift_o))
    else $error("strobe beyond byte end");

  a_slave_pins: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_reg.peripheral_enable_bit && !ctrl_reg.master_select_bit)
      |-> (pins_o.sck_oe_n && pins_o.mosi_oe_n && !pins_o.miso_oe_n))
    else $error("slave pin roles wrong");

  a_read_back: assert property (@(posedge clk_i) disable iff (rst_i)
    (fire && !wb_we_i && wb_adr_i == serial_control_pkg::SERIAL_CONTROL_ADR_CTRL)
      |=> wb_ack_o && wb_dat_o[7:0] == $past(ctrl_reg))
    else $error("control read back wrong");

endmodule : serial_control_core

`default_nettype wire

/* serial_control_far_end.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_control_far_end (
  input wire logic clk_i,
  input wire logic sel_i,
  input wire logic run_i,
  input wire logic clock_polarity_i,
  output logic ss_n_o,
  output logic sck_o
);
  logic [1:0] cnt_reg;
  logic tog_reg;
  assign ss_n_o = ~sel_i;
  // The clock rests at the shared polarity outside frames.
  assign sck_o = clock_polarity_i ^ tog_reg;
  always_ff @(posedge clk_i) begin
    cnt_reg <= run_i ? cnt_reg + 2'd1 : 2'd0;
    if (!run_i) tog_reg <= 1'b0;
    else if (cnt_reg == 2'd2) tog_reg <= ~tog_reg;
  end
endmodule : serial_control_far_end
`default_nettype wire

/* serial_control_control_register_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_control_control_register_tb_top;
  localparam logic [7:0] AC = serial_control_pkg::SERIAL_CONTROL_ADR_CTRL;
  localparam logic [7:0] AS = serial_control_pkg::SERIAL_CONTROL_ADR_STATUS;
  localparam logic [7:0] AM = serial_control_pkg::SERIAL_CONTROL_ADR_MASK;
  logic clk, rst, cyc, stb, we, ack, ss_n, sck_in, xact, tdone, overrun_flag, sck, cap, shf, irq;
  logic p_sel, p_run;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat_w, dat_r, v;
  serial_control_pkg::serial_control_pins_s pins;
  serial_control_pkg::serial_control_ctrl_s ctl;
  logic [31:0] exp_q[$];
  int n_fail = 0;
  int n_tests = 0;
  int divs[8] = '{8, 16, 64, 128, 4, 8, 32, 64};
  int t, t0, k;
  logic prev, pcap, pshf, seen;
  logic [2:0] c;
  serial_control_core dut_u (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
    .ss_n_i(ss_n), .sck_i(sck_in), .xfer_active_i(xact), .transfer_done_i(tdone),
    .overrun_i(overrun_flag), .sck_o(sck), .pins_o(pins), .ctrl_o(ctl), .capture_o(cap),
    .shift_o(shf), .irq_o(irq));
  serial_control_far_end far_u (.clk_i(clk), .sel_i(p_sel), .run_i(p_run), .clock_polarity_i(1'b0),
    .ss_n_o(ss_n), .sck_o(sck_in));
  task automatic chk_rd(input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask : chk_rd
  task automatic chk_pin(input logic e, input logic g);
    chk_rd({31'h0, e}, {31'h0, g});
  endtask : chk_pin
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    sel <= s;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0000_0000, 4'h1);
  endtask : rd
  task automatic pulse_ev(input logic which);
    @(posedge clk);
    if (which) tdone <= 1'b1;
    else overrun_flag <= 1'b1;
    @(posedge clk);
    tdone <= 1'b0;
    overrun_flag <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : pulse_ev
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0) begin
      if (exp_q.size() == 0) chk_rd(32'hffff_ffff, dat_r);
      else chk_rd(exp_q.pop_front(), dat_r);
    end
  end
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #200000;
    n_fail++;
    test_done();
  end
  initial begin
    {rst, cyc, stb, we, xact, tdone, overrun_flag, p_sel, p_run} = 9'h100;
    adr = 8'h00;
    sel = 4'h0;
    dat_w = 32'h0000_0000;
    void'($urandom(32'hdfde2981));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk_rd({28'h0, 4'hE}, {28'h0, pins});
    chk_pin(1'b0, sck);
    rd(AC, 32'h0000_0000);
    rd(AS, 32'h0000_0000);
    rd(AM, 32'h0000_00B0);
    rd(8'h0C, 32'h0000_0000);
    repeat (4) begin
      v = $urandom & 32'h0000_00FF;
      wr(AC, v);
      bus(1'b1, AC, ~v, 4'hE);
      rd(AC, v);
    end
    wr(AC, 32'h0000_0080);
    pulse_ev(1'b1);
    chk_pin(1'b1, irq);
    rd(AS, 32'h0000_0080);
    wr(AM, 32'h0000_0000);
    #1 chk_pin(1'b0, irq);
    wr(AM, 32'h0000_00B0);
    #1 chk_pin(1'b1, irq);
    wr(AS, 32'h0000_0080);
    #1 chk_pin(1'b0, irq);
    wr(AC, 32'h0000_0000);
    pulse_ev(1'b0);
    chk_pin(1'b0, irq);
    rd(AS, 32'h0000_0020);
    wr(AS, 32'h0000_0020);
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      wr(AC, 32'h0000_0000);
      wr(AC, {24'h0, 2'b01, c[2], 1'b1, c[0], c[1], c[1:0]});
      #1 chk_pin(c[0], sck);
      chk_rd({28'h0, 4'h3}, {28'h0, pins});
      chk_rd({24'h0, 2'b01, c[2], 1'b1, c[0], c[1], c[1:0]}, {24'h0, ctl});
      @(posedge clk);
      xact <= 1'b1;
      prev = c[0];
      pcap = 1'b0;
      pshf = 1'b0;
      t = 0;
      t0 = 0;
      k = 0;
      while (k < 2 && t < 400) begin
        @(posedge clk);
        #1;
        t++;
        if (sck !== prev) begin
          if (k == 0) chk_pin(c[1], pshf);
          if (k == 0) chk_pin(~c[1], pcap);
          else chk_rd(32'(divs[i] / 2), 32'(t - t0));
          t0 = t;
          k++;
          prev = sck;
        end
        pcap = cap;
        pshf = shf;
      end
      chk_pin(1'b1, 1'(k == 2));
      @(posedge clk);
      xact <= 1'b0;
      repeat (3) @(posedge clk);
      #1 chk_pin(c[0], sck);
    end
    wr(AC, 32'h0000_0040 | ($urandom & 32'h0000_0023));
    p_sel <= 1'b1;
    p_run <= 1'b1;
    xact <= 1'b1;
    seen = 1'b0;
    repeat (40) begin
      @(posedge clk);
      #1;
      seen = seen | cap;
    end
    chk_pin(1'b1, seen);
    chk_rd({28'h0, 4'hD}, {28'h0, pins});
    @(posedge clk);
    {p_sel, p_run, xact} <= 3'b000;
    wr(AC, 32'h0000_0050);
    @(posedge clk);
    p_sel <= 1'b1;
    repeat (3) @(posedge clk);
    p_sel <= 1'b0;
    rd(AC, 32'h0000_0000);
    wr(AC, 32'h0000_0050);
    rd(AC, 32'h0000_0000);
    rd(AS, 32'h0000_0010);
    wr(AC, 32'h0000_0050);
    rd(AC, 32'h0000_0050);
    rd(AS, 32'h0000_0000);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(AC, 32'h0000_0000);
    rd(AM, 32'h0000_00B0);
    wr(AC, 32'h0000_0000);
    test_done();
  end
endmodule : serial_control_control_register_tb_top
`default_nettype wire
